// >>> design/uca_pkg.sv
// uca_pkg: register map, field positions, reset values and frame counts
// assumes an APB slave with byte addresses and a 40 MHz clk
// What this block does
// R1: 8-bit async with filter on: receive-done needs valid stop and address hit
// R2: 9-bit modes with filter on: receive-done needs ninth bit one and address hit
// R3: invalid stop bit at frame end sets the frame error flag
// R4: frame error flag survives later good frames; only a software write clears it
// R5: control bit 7 shows frame error when error view is 1, else mode bit zero
// R6: frame error is set on a bad stop bit whatever the error view select
// R7: mode bits pick shift register, 8-bit UART, fixed or variable 9-bit UART
// R8: in shift mode the shift clock idles at the inverse of filter enable
// R9: transmit-done rises after 8th bit in shift mode, at stop start otherwise
// R10: receive-done rises mid stop bit in async modes, after 8th bit in shift mode
// R11: 9-bit frame is start, eight data LSB first, ninth bit, stop: 11 bits
// R12: async reception starts on a start bit only while receive enable is 1
// R13: with error view 0, bit 7 writes touch mode bit zero, not frame error
package uca_pkg;
  // byte addresses on the APB
  localparam logic [7:0] OFS_CTRL = 8'h98;
  localparam logic [7:0] OFS_AUX = 8'h9C;
  localparam logic [7:0] OFS_DATA = 8'hA0;
  localparam logic [7:0] OFS_ADDR = 8'hA4;
  // serial_port_control fields
  localparam int CTL_M0_FE = 7;
  localparam int CTL_M1 = 6;
  localparam int CTL_AFE = 5;
  localparam int CTL_RXEN = 4;
  localparam int CTL_TX9 = 3;
  localparam int CTL_RX9 = 2;
  localparam int CTL_TXDONE = 1;
  localparam int CTL_RXDONE = 0;
  // aux fields
  localparam int AUX_EVS = 0;
  localparam int AUX_DBL = 1;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] AUX_RST = 2'h0;
  localparam logic [7:0] GIVEN_RST = 8'h00;
  localparam logic [7:0] BCAST_RST = 8'hFF;
  // mode encodings
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_UART8 = 2'h1;
  localparam logic [1:0] MODE_UART9_FIX = 2'h2;
  localparam logic [1:0] MODE_UART9_VAR = 2'h3;
  // sixteen ticks per async bit, sampled at the middle
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TICK_MID = 4'h7;
  // last bit index of a frame: shift 8 bits, 10-bit and 11-bit frames
  localparam logic [3:0] M0_LAST = 4'h7;
  localparam logic [3:0] LAST8 = 4'h9;
  localparam logic [3:0] LAST9 = 4'hA;
endpackage

// >>> design/uca_tick_gen.sv
// uca_tick_gen: rate tick for both serial engines
// assumes timer_ovf is a one-cycle pulse from an outside timer
`timescale 1ns/100ps
module uca_tick_gen (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // rate selection
  input wire logic use_timer,
  input wire logic timer_ovf,
  input wire logic speed_double,
  // tick out
  output logic tick
);
  logic half;
  wire src = use_timer ? timer_ovf : 1'b1;

  // undoubled rate halves the source; gives osc/4 or timer/4 in shift mode, osc/32 or timer/32 async
  assign tick = src & (speed_double | half);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      half <= 1'b0;
    end else if (src) begin
      half <= ~half;
    end
  end
endmodule

// >>> design/uca_serial_ctrl.sv
// uca_serial_ctrl: serial port control, address filter and frame engines
// assumes an APB master on clk, synchronous inputs, timer_ovf from outside
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
module uca_serial_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // rate source
  input wire logic timer_ovf,
  // serial pins
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe_n,
  output logic txd
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uca_rx_e;
  typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, M0_ACT, M0_REST} uca_tx_e;

  uca_rx_e rx_st;
  uca_tx_e tx_st;
  logic mode0, mode1, afe, rx_en, tx9, rx9, tx_done, rx_done, fe;
  logic evs, dbl;
  logic [7:0] given, bcast, rx_buf;
  logic [3:0] rx_cnt, rx_bits, tx_cnt, tx_bits;
  logic [8:0] rx_sh;
  logic [10:0] tx_sh;
  logic m0_rx;
  logic tick;

  // bus decode
  wire acc = psel & penable;
  wire hit_ctrl = paddr == uca_pkg::OFS_CTRL;
  wire hit_aux = paddr == uca_pkg::OFS_AUX;
  wire hit_data = paddr == uca_pkg::OFS_DATA;
  wire hit_addr = paddr == uca_pkg::OFS_ADDR;
  wire hit_any = hit_ctrl | hit_aux | hit_data | hit_addr;
  wire ctrl_wr = acc & pwrite & hit_ctrl;
  wire aux_wr = acc & pwrite & hit_aux;
  wire data_wr = acc & pwrite & hit_data;
  wire addr_wr = acc & pwrite & hit_addr;
  assign pready = 1'b1;
  assign pslverr = acc & ~hit_any;

  // mode decode
  wire [1:0] mode = {mode0, mode1}; // R7
  wire m0 = mode == uca_pkg::MODE_SHIFT;
  wire nine = mode0;
  wire use_timer = m0 ? tx9 : (mode != uca_pkg::MODE_UART9_FIX); // R7
  wire bit7_view = evs ? fe : mode0; // R5
  wire [7:0] ctrl_rd = {bit7_view, mode1, afe, rx_en, tx9, rx9, tx_done, rx_done};
  wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_rd} :
                       hit_aux ? {30'h0, dbl, evs} :
                       hit_data ? {24'h000000, rx_buf} :
                       hit_addr ? {16'h0000, bcast, given} : 32'h00000000;

  uca_tick_gen u_tick (
    .clk(clk),
    .sys_rst(sys_rst),
    .use_timer(use_timer),
    .timer_ovf(timer_ovf),
    .speed_double(dbl),
    .tick(tick)
  );

  // async receive decisions at the stop sample
  wire rx_ev = tick & (rx_st == RX_STOP) & (rx_cnt == uca_pkg::TICK_LAST); // R10
  wire stop_ok = rxd_i;
  wire [7:0] byte_w = nine ? rx_sh[7:0] : rx_sh[8:1];
  wire ninth_w = nine ? rx_sh[8] : stop_ok;
  wire addr_hit = (byte_w == given) | (byte_w == bcast);
  wire rx_accept = ~afe | (nine ? (ninth_w & addr_hit) : (stop_ok & addr_hit)); // R1 R2
  wire fe_set = rx_ev & ~stop_ok; // R3 R6
  wire [3:0] rx_last = nine ? uca_pkg::M0_LAST + 4'h1 : uca_pkg::M0_LAST;

  // shift mode and async transmit engine
  wire tx_idle = tx_st == TX_IDLE;
  wire m0_idle = m0 & tx_idle;
  wire m0_step = tick & (tx_st == M0_REST);
  wire m0_end = m0_step & (tx_bits == uca_pkg::M0_LAST);
  wire m0_rx_go = m0_idle & rx_en & ~rx_done & ~data_wr;
  wire [3:0] tx_last = nine ? uca_pkg::LAST9 : uca_pkg::LAST8; // R11
  wire tx_step = tick & (tx_st == TX_ASYNC) & (tx_cnt == uca_pkg::TICK_LAST);
  wire tx_done_set = (tx_step & (tx_bits == tx_last - 4'h1)) | (m0_end & ~m0_rx); // R9
  wire rx_done_set = (rx_ev & rx_accept) | (m0_end & m0_rx); // R10
  wire [7:0] m0_byte = {rxd_i, tx_sh[7:1]};

  // control register next values; hardware set beats software clear
  wire next_tx_done = tx_done_set | (ctrl_wr ? pwdata[uca_pkg::CTL_TXDONE] : tx_done);
  wire next_rx_done = rx_done_set | (ctrl_wr ? pwdata[uca_pkg::CTL_RXDONE] : rx_done);
  wire next_fe = fe_set | ((ctrl_wr & evs) ? pwdata[uca_pkg::CTL_M0_FE] : fe); // R4 R5 R13
  wire next_mode0 = (ctrl_wr & ~evs) ? pwdata[uca_pkg::CTL_M0_FE] : mode0; // R13
  wire next_rx9 = (rx_ev & rx_accept) ? ninth_w : (ctrl_wr ? pwdata[uca_pkg::CTL_RX9] : rx9);
  wire next_txd = m0 ? (tx_st == M0_ACT ? afe : ~afe) : (tx_st == TX_ASYNC ? tx_sh[0] : 1'b1); // R8
  wire next_oe_n = ~((tx_st == M0_ACT || tx_st == M0_REST) & ~m0_rx);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {mode0, mode1, afe, rx_en, tx9, rx9, tx_done, rx_done} <= uca_pkg::CTRL_RST;
      fe <= 1'b0;
      {dbl, evs} <= uca_pkg::AUX_RST;
      given <= uca_pkg::GIVEN_RST;
      bcast <= uca_pkg::BCAST_RST;
    end else begin
      if (ctrl_wr) begin
        {mode1, afe, rx_en, tx9} <= pwdata[6:3];
      end
      mode0 <= next_mode0;
      rx9 <= next_rx9;
      tx_done <= next_tx_done;
      rx_done <= next_rx_done;
      fe <= next_fe;
      if (aux_wr) begin
        {dbl, evs} <= pwdata[1:0];
      end
      if (addr_wr) begin
        {bcast, given} <= pwdata[15:0];
      end
    end
  end

  // read data registered in the setup cycle, so the access phase is zero wait
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
      rx_buf <= 8'h00;
      txd <= 1'b1;
      rxd_oe_n <= 1'b1;
    end else begin
      if (psel & ~penable & ~pwrite) begin
        prdata <= rd_mux;
      end
      if (rx_ev & rx_accept) begin
        rx_buf <= byte_w;
      end else if (m0_end & m0_rx) begin
        rx_buf <= m0_byte;
      end
      txd <= next_txd;
      rxd_oe_n <= next_oe_n;
    end
  end

  // async receiver; start bit is re-checked mid bit to reject glitches
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_st <= RX_IDLE;
      rx_cnt <= 4'h0;
      rx_bits <= 4'h0;
      rx_sh <= 9'h000;
    end else begin
      case (rx_st)
        RX_IDLE: begin
          rx_cnt <= 4'h0;
          if (~m0 & rx_en & ~rxd_i) begin // R12
            rx_st <= RX_START;
          end
        end
        RX_START: if (tick) begin
          rx_cnt <= rx_cnt + 4'h1;
          if (rx_cnt == uca_pkg::TICK_MID) begin
            rx_cnt <= 4'h0;
            rx_bits <= 4'h0;
            rx_st <= rxd_i ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: if (tick) begin
          rx_cnt <= rx_cnt + 4'h1;
          if (rx_cnt == uca_pkg::TICK_LAST) begin
            rx_sh <= {rxd_i, rx_sh[8:1]}; // R11
            rx_bits <= rx_bits + 4'h1;
            if (rx_bits == rx_last) begin
              rx_st <= RX_STOP;
            end
          end
        end
        RX_STOP: if (tick) begin
          rx_cnt <= rx_cnt + 4'h1;
          if (rx_ev) begin
            rx_st <= RX_IDLE;
          end
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // transmitter; in shift mode it also clocks reception, one bit per two ticks
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_st <= TX_IDLE;
      tx_cnt <= 4'h0;
      tx_bits <= 4'h0;
      tx_sh <= 11'h7FF;
      m0_rx <= 1'b0;
    end else begin
      case (tx_st)
        TX_IDLE: begin
          tx_cnt <= 4'h0;
          tx_bits <= 4'h0;
          if (data_wr) begin
            m0_rx <= 1'b0;
            tx_sh <= m0 ? {3'h7, pwdata[7:0]} :
                     nine ? {1'b1, tx9, pwdata[7:0], 1'b0} : {2'h3, pwdata[7:0], 1'b0}; // R11
            tx_st <= m0 ? M0_ACT : TX_ASYNC;
          end else if (m0_rx_go) begin
            m0_rx <= 1'b1;
            tx_st <= M0_ACT;
          end
        end
        TX_ASYNC: if (tick) begin
          tx_cnt <= tx_cnt + 4'h1;
          if (tx_step) begin
            tx_sh <= {1'b1, tx_sh[10:1]};
            tx_bits <= tx_bits + 4'h1;
            if (tx_bits == tx_last) begin
              tx_st <= TX_IDLE;
            end
          end
        end
        M0_ACT: if (tick) begin
          tx_st <= M0_REST;
        end
        M0_REST: if (tick) begin
          tx_sh <= {3'h7, m0_byte};
          tx_bits <= tx_bits + 4'h1;
          tx_st <= m0_end ? TX_IDLE : M0_ACT; // R9 R10
        end
        default: tx_st <= TX_IDLE;
      endcase
    end
  end

  assign rxd_o = tx_sh[0];

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_fe_bad_stop: assert property (fe_set |=> fe) // R3
    else $error("frame error not set after bad stop bit");
  a_fe_any_view: assert property (rx_ev && !rxd_i && !evs && !ctrl_wr
      |=> fe && mode0 == $past(mode0)) // R6
    else $error("hidden frame error not set");
  a_fe_sticky: assert property (fe && !(ctrl_wr && evs) |=> fe) // R4
    else $error("frame error cleared without software write");
  a_fe_hidden_wr: assert property (ctrl_wr && !evs && !fe_set |=> $stable(fe)) // R13
    else $error("bit 7 write with error view off touched frame error");
  a_bit7_view: assert property (psel && !penable && !pwrite && hit_ctrl
      |=> prdata[7] == ($past(evs) ? $past(fe) : $past(mode0))) // R5
    else $error("bit 7 read shows the wrong view");
  a_filter_nine: assert property (rx_ev && afe && nine && !ninth_w && !ctrl_wr
      |=> $stable(rx_done)) // R2
    else $error("receive-done raised for data byte with filter on");
  a_filter_stop: assert property (rx_ev && afe && !nine && !stop_ok && !ctrl_wr
      |=> $stable(rx_done)) // R1
    else $error("receive-done raised on bad stop with filter on");
  a_clk_idle: assert property ($past(m0_idle) && m0_idle && $stable(afe) |-> txd == !afe) // R8
    else $error("shift clock idle level wrong");
  a_tx_done_stop: assert property (tx_done_set && !m0 |=> tx_done ##1 txd) // R9
    else $error("transmit-done not at stop bit start");
  a_rx_gate: assert property (rx_st == RX_IDLE && !rx_en |=> rx_st == RX_IDLE) // R12
    else $error("reception started with receive disabled");
  a_rx_mid_stop: assert property (rx_ev && rx_accept && !ctrl_wr |=> rx_done) // R10
    else $error("receive-done missing at mid stop");
endmodule

// >>> tb/uca_node.sv
// uca_node: remote serial node sending frames onto the receive pin
// assumes frames are started by the bench through the send task
`timescale 1ns/100ps
module uca_node (
  // clock
  input wire logic clk,
  // line toward the block
  output logic line
);
  // mark level between frames, as the line rests when nobody sends
  initial line = 1'b1;
  // start, eight data lsb first, [ninth], stop; per = clk cycles per bit
  task send(input logic [7:0] b, input logic n9, input logic stp, input int nb, input int per);
    logic [10:0] f;
    f = {stp, n9, b, 1'b0};
    if (nb == 10) begin
      f = {1'b1, stp, b, 1'b0};
    end
    for (int i = 0; i < nb; i++) begin
      @(posedge clk);
      line <= f[i];
      repeat (per - 1) @(posedge clk);
    end
    @(posedge clk);
    line <= 1'b1;
  endtask
endmodule

// >>> tb/tb.sv
// tb: self-checking bench for the serial control block
// assumes apb master here, uca_node on the receive pin, timer pulse every 2nd clk
`timescale 1ns/100ps
module tb;
  localparam logic [7:0] C = uca_pkg::OFS_CTRL;
  localparam logic [7:0] A = uca_pkg::OFS_AUX;
  localparam logic [7:0] D = uca_pkg::OFS_DATA;
  localparam logic [7:0] G = uca_pkg::OFS_ADDR;
  logic clk, sys_rst, psel, penable, pwrite, rxd_i;
  logic timer_ovf = 1'b0;
  logic pready, pslverr, rxd_o, rxd_oe_n, txd, e;
  logic [7:0] paddr, g, byt;
  logic [31:0] pwdata, prdata, q;
  int n_fail, comparisons, i, acc;
  int cyc = 0;
  // model of accepted receive bytes, oldest first
  logic [7:0] exp_q[$];
  uca_serial_ctrl uca_serial_ctrl_i(.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_ovf(timer_ovf), .rxd_i(rxd_i),
    .rxd_o(rxd_o), .rxd_oe_n(rxd_oe_n), .txd(txd));
  uca_node uca_node_i(.clk(clk), .line(rxd_i));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    timer_ovf <= !timer_ovf;
    cyc = cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      finish_test();
    end
  end
  task finish_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask
  // held from setup until pready is seen high, then released
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input string s, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(s, q & m, exp & m);
  endtask
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_fail = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    void'($urandom(63740));
    g = 8'($urandom()) & 8'h7E;
    rd("ctrl reset", C, 32'h00, 32'hFFFFFFFF);
    rd("unmapped", 8'hB0, 32'h0, 32'hFFFFFFFF);
    chk("slverr", {31'h0, e}, 32'h1);
    for (i = 0; i < 4; i++) begin
      wr(C, i << 6);
      rd("mode", C, i << 6, 32'hFF);
    end
    wr(C, 32'h20);
    repeat (4) @(posedge clk);
    chk("clk idle lo", {31'h0, txd}, 32'h0);
    wr(C, 32'h00);
    repeat (4) @(posedge clk);
    chk("clk idle hi", {31'h0, txd}, 32'h1);
    wr(A, 32'h2);
    wr(G, {16'h0, 8'hFF, g});
    wr(C, 32'hB0);
    // given hit, miss, broadcast, given with ninth bit zero
    for (i = 0; i < 4; i++) begin
      byt = (i == 2) ? 8'hFF : ((i == 1) ? (g ^ 8'h01) : g);
      acc = (i % 2 == 0);
      if (acc) exp_q.push_back(byt);
      uca_node_i.send(byt, i != 3, 1'b1, 11, 16);
      rd("filter9", C, 32'hB0 | (acc ? 5 : 0), 32'hFF);
      if (acc) rd("rxbuf", D, {24'h0, exp_q.pop_front()}, 32'hFF);
      wr(C, 32'hB0);
    end
    wr(C, 32'h90);
    uca_node_i.send(g, 1'b0, 1'b0, 11, 16);
    rd("fe hidden", C, 32'h80, 32'h80);
    wr(C, 32'h00);
    wr(A, 32'h3);
    rd("fe kept", C, 32'h80, 32'hFF);
    wr(A, 32'h2);
    wr(C, 32'h90);
    wr(A, 32'h3);
    uca_node_i.send(g, 1'b1, 1'b1, 11, 16);
    rd("fe sticky", C, 32'h95, 32'hFF);
    wr(C, 32'h10);
    rd("fe clear", C, 32'h10, 32'hFF);
    wr(A, 32'h2);
    rd("mode kept", C, 32'h90, 32'hFF);
    wr(C, 32'h70);
    uca_node_i.send(g, 1'b0, 1'b0, 10, 32);
    rd("bad stop", C, 32'h70, 32'hFB);
    wr(A, 32'h3);
    rd("fe mode1", C, 32'hF0, 32'hFB);
    // a low stop can pass for the next start bit; let any such frame run out
    repeat (400) @(posedge clk);
    wr(C, 32'h70);
    wr(A, 32'h2);
    uca_node_i.send(g, 1'b0, 1'b1, 10, 32);
    rd("good stop", C, 32'h71, 32'hFB);
    rd("rxbuf m1", D, {24'h0, g}, 32'hFF);
    wr(C, 32'h70);
    uca_node_i.send(g ^ 8'h01, 1'b0, 1'b1, 10, 32);
    rd("miss mode1", C, 32'h70, 32'hFB);
    wr(C, 32'h80);
    uca_node_i.send(g, 1'b1, 1'b1, 11, 16);
    rd("rx off", C, 32'h80, 32'hFF);
    wr(D, 32'h3C);
    i = 0;
    while (txd !== 1'b0 && i < 50) begin
      @(posedge clk);
      i++;
    end
    // stop bit begins ten bit times after the start edge
    repeat (146) @(posedge clk);
    rd("tx early", C, 32'h0, 32'h2);
    repeat (20) @(posedge clk);
    rd("tx done", C, 32'h2, 32'h2);
    // shift mode send: data pin driven, one bit per low phase of the shift clock
    byt = 8'($urandom());
    wr(C, 32'h00);
    wr(D, {24'h0, byt});
    for (i = 0; i < 8; i++) begin
      @(negedge txd);
      @(negedge clk);
      chk("shift out", {30'h0, rxd_oe_n, rxd_o}, {31'h0, byt[i]});
    end
    rd("m0 done", C, 32'h2, 32'h2);
    finish_test();
  end
endmodule
